// ==== su_serial_unit.sv ====
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
// Operation
// - All four serial requests also leave on one shared interrupt output.
// - Transmit-empty request while its flag and enable are both one.
// - Transmit-done request while its flag and enable are both one.
// - Receive-full and receive-error requests, both gated by the receive interrupt enable.
// - Transmit-empty and transmit-done flags reset to one.
// - Buffer write clears transmit-empty; move to shift register sets it.
// - Buffer writes always accepted; unsent byte is overwritten.
// - Overrun sets its flag, keeps receive-full, skips the buffer copy.
// - Coinciding errors set all flags; reading after overrun clears receive-full.
// - Reception halts while an error is pending and restarts during a break once the errors are cleared, so framing fault reappears.
// - Clearing transmit enable resets the transmitter unless synchronous receive is on; pin follows port latch.
// - Synchronous transmit never starts while a receive error flag is set.
// - Clearing receive enable leaves the error flags alone.
// - Asynchronous receiver runs at sixteen times bit rate, syncs on start.
// - Each bit is latched on the eighth basic-clock edge.
// - Frame end with receive-full set is an overrun, unless the receive buffer is read in the same cycle.
// - Reading the receive buffer clears receive-full.
// - Stop bit sent with empty buffer sets transmit-done and marks line.
module su_serial_unit (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_line,
	output logic tx_line_o,
	output logic tx_line_oe_n,
	output logic serial_clk_o,
	output logic serial_clk_oe_n,
	output logic rx_full_irq,
	output logic tx_empty_irq,
	output logic tx_done_irq,
	output logic rx_error_irq,
	output logic serial_irq
);
	import su_pkg::*;
	logic [7:0] mode_q, ctrl_q, port_q, baud_q, tx_buf_q, rx_buf_q, rdata_q;
	logic tx_empty_q, tx_done_q, rx_full_q, ovr_q, fer_q, per_q;
	su_tx_state_t tx_st;
	logic [3:0] ph_q;
	logic [2:0] bit_q;
	logic [7:0] tx_sh_q, rx_sh_q;
	logic par_q, rx_act_q, srx_end_q;
	logic tick, bit_end, sync, err_any, tx_on, rx_on, buf_wr, buf_rd, stat_wr;
	logic load, tx_go, arx_done, arx_perr, arx_ferr, rx_lvl, rx_end, end_fer, end_per;
	logic [7:0] arx_data, end_data;

	assign sync = mode_q[MODE_SYNC];
	assign tx_on = ctrl_q[CTRL_TX_ON];
	assign rx_on = ctrl_q[CTRL_RX_ON];
	assign err_any = ovr_q | fer_q | per_q;
	assign buf_wr = reg_wr && (reg_addr == ADDR_TXBUF);
	assign buf_rd = reg_rd && (reg_addr == ADDR_RXBUF);
	assign stat_wr = reg_wr && (reg_addr == ADDR_STAT);

	////////////////////////////////////////////////////////////////
	// Submodules
	su_baud u_baud (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.divisor(baud_q),
		.tick(tick)
	);

	// Receiver halts while any error is pending, as a stuck flag would hide data
	su_rx u_rx (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.rx_line(rx_line),
		.tick(tick),
		.enable(rx_on && !sync && !err_any),
		.par_en(mode_q[MODE_PAR_EN]),
		.par_odd(mode_q[MODE_PAR_ODD]),
		.rx_lvl(rx_lvl),
		.done(arx_done),
		.data(arx_data),
		.par_err(arx_perr),
		.frm_err(arx_ferr)
	);

	////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_RST;
			ctrl_q <= CTRL_RST;
			port_q <= PORT_RST;
			baud_q <= BAUD_RST;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_MODE) mode_q <= reg_wdata;
			if (reg_addr == ADDR_CTRL) ctrl_q <= reg_wdata;
			if (reg_addr == ADDR_PORT) port_q <= reg_wdata;
			if (reg_addr == ADDR_BAUD) baud_q <= reg_wdata;
		end
	end

	// Write-anytime buffer; an unsent byte is simply replaced
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_buf_q <= BUF_RST;
		end else if (buf_wr) begin
			tx_buf_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit engine; shared bit timing also clocks synchronous receive
	assign bit_end = tick && (ph_q == OVS_LAST);
	assign tx_go = tx_on && !tx_empty_q && !(sync && err_any);
	assign load = (tx_st == TX_IDLE || ((tx_st == TX_STOP || (sync && bit_q == BITS_LAST
		&& tx_st == TX_DATA)) && bit_end)) && tx_go;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_st <= TX_IDLE;
			ph_q <= 4'h0;
			bit_q <= 3'h0;
			tx_sh_q <= 8'hFF;
			par_q <= 1'b0;
			rx_act_q <= 1'b0;
		end else if (!tx_on && !(sync && rx_on)) begin
			tx_st <= TX_IDLE;
			ph_q <= 4'h0;
			bit_q <= 3'h0;
			tx_sh_q <= 8'hFF;
		end else begin
			if (tick) ph_q <= ph_q + 4'h1;
			if (load || (tx_st == TX_IDLE && sync && rx_on && !err_any)) begin
				// A receive-only synchronous frame sends ones
				tx_sh_q <= load ? tx_buf_q : 8'hFF;
				par_q <= mode_q[MODE_PAR_ODD];
				rx_act_q <= rx_on;
				bit_q <= 3'h0;
				if (tx_st == TX_IDLE) ph_q <= 4'h0;
				tx_st <= sync ? TX_DATA : TX_START;
			end else if (bit_end) begin
				unique case (tx_st)
					TX_IDLE: tx_st <= TX_IDLE;
					TX_START: tx_st <= TX_DATA;
					TX_DATA: begin
						par_q <= par_q ^ tx_sh_q[0];
						tx_sh_q <= {1'b1, tx_sh_q[7:1]};
						bit_q <= bit_q + 3'h1;
						if (bit_q == BITS_LAST) begin
							tx_st <= sync ? TX_IDLE : (mode_q[MODE_PAR_EN] ? TX_PAR : TX_STOP);
						end
					end
					TX_PAR: tx_st <= TX_STOP;
					TX_STOP: tx_st <= TX_IDLE;
				endcase
			end
		end
	end

	// Synchronous receive: sample on the rising serial clock, end with the last bit
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_sh_q <= BUF_RST;
			srx_end_q <= 1'b0;
		end else begin
			srx_end_q <= sync && rx_act_q && tx_st == TX_DATA && bit_end && bit_q == BITS_LAST;
			if (sync && tx_st == TX_DATA && tick && ph_q == SAMPLE_PT) begin
				rx_sh_q <= {rx_lvl, rx_sh_q[7:1]};
			end
		end
	end

	assign rx_end = arx_done || srx_end_q;
	assign end_data = sync ? rx_sh_q : arx_data;
	assign end_fer = !sync && arx_ferr;
	assign end_per = !sync && arx_perr;

	////////////////////////////////////////////////////////////////
	// Transmit flags: the software clear wins over the hardware set
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_empty_q <= 1'b1;
			tx_done_q <= 1'b1;
		end else begin
			if (buf_wr) tx_empty_q <= 1'b0;
			else if (load) tx_empty_q <= 1'b1;
			if (load || buf_wr) tx_done_q <= 1'b0;
			else if (tx_st == TX_STOP && bit_end) tx_done_q <= 1'b1;
		end
	end

	// Receive buffer and flags; errors clear only by writing zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_buf_q <= BUF_RST;
			rx_full_q <= 1'b0;
			ovr_q <= 1'b0;
			fer_q <= 1'b0;
			per_q <= 1'b0;
		end else begin
			if (stat_wr) begin
				if (!reg_wdata[STAT_RXF]) rx_full_q <= 1'b0;
				if (!reg_wdata[STAT_OVR]) ovr_q <= 1'b0;
				if (!reg_wdata[STAT_FER]) fer_q <= 1'b0;
				if (!reg_wdata[STAT_PER]) per_q <= 1'b0;
			end
			if (buf_rd) rx_full_q <= 1'b0;
			if (rx_end) begin
				if (end_fer) fer_q <= 1'b1;
				if (end_per) per_q <= 1'b1;
				// A read in the same cycle frees the buffer, so the new byte lands
				if (rx_full_q && !buf_rd) begin
					ovr_q <= 1'b1;
				end else begin
					rx_buf_q <= end_data;
					if (!end_fer && !end_per) rx_full_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port: data stands in the cycle after the strobe only
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_MODE: rdata_q <= mode_q;
				ADDR_CTRL: rdata_q <= ctrl_q;
				ADDR_TXBUF: rdata_q <= tx_buf_q;
				ADDR_STAT: rdata_q <= {tx_empty_q, rx_full_q, ovr_q, fer_q, per_q, tx_done_q, 2'b00};
				ADDR_RXBUF: rdata_q <= rx_buf_q;
				ADDR_PORT: rdata_q <= port_q;
				ADDR_BAUD: rdata_q <= baud_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////
	// Pins; with transmit off the line is a plain port pin
	always_comb begin
		if (tx_on) begin
			tx_line_oe_n = 1'b0;
			unique case (tx_st)
				TX_START: tx_line_o = 1'b0;
				TX_DATA: tx_line_o = tx_sh_q[0];
				TX_PAR: tx_line_o = par_q;
				default: tx_line_o = 1'b1;
			endcase
		end else begin
			tx_line_oe_n = !port_q[PORT_DIR];
			tx_line_o = port_q[PORT_DAT];
		end
	end

	// Clock output low in the first half bit, idles high between frames
	assign serial_clk_oe_n = !(sync && !ctrl_q[CTRL_CKS1]);
	assign serial_clk_o = !(sync && tx_st == TX_DATA && ph_q < SAMPLE_PT);

	// Requests, each also merged onto one shared output
	assign tx_empty_irq = tx_empty_q && ctrl_q[CTRL_TXE_IE];
	assign tx_done_irq = tx_done_q && ctrl_q[CTRL_TXD_IE];
	assign rx_full_irq = rx_full_q && ctrl_q[CTRL_RX_IE];
	assign rx_error_irq = err_any && ctrl_q[CTRL_RX_IE];
	assign serial_irq = tx_empty_irq | tx_done_irq | rx_full_irq | rx_error_irq;

	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_stop_sent;
		tx_on && tx_st == TX_STOP && bit_end && tx_empty_q && !buf_wr;
	endsequence
	sequence s_marked;
		tx_done_q && tx_line_o && tx_st == TX_IDLE;
	endsequence

	a_irq_shared: assert property (@(posedge ref_clk) disable iff (!resetn)
		(rx_error_irq || tx_done_irq) |-> serial_irq) else $error("shared request missing");
	a_txe_request: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(tx_empty_q) && ctrl_q[CTRL_TXE_IE] |-> tx_empty_irq) else $error("empty request missing");
	a_flags_reset: assert property (@(posedge ref_clk)
		$rose(resetn) |-> tx_empty_q && tx_done_q) else $error("transmit flags not one at reset");
	a_buf_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		buf_wr |=> !tx_empty_q && !tx_done_q) else $error("buffer write kept empty flag");
	a_overrun_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
		rx_end && rx_full_q && !buf_rd && !stat_wr |=> ovr_q && rx_full_q && $stable(rx_buf_q))
		else $error("overrun handled wrongly");
	a_tx_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		!tx_on && !sync |=> tx_st == TX_IDLE && ph_q == 4'h0 && bit_q == 3'h0 && tx_sh_q == 8'hFF)
		else $error("transmitter not reset");
	a_sync_block: assert property (@(posedge ref_clk) disable iff (!resetn)
		tx_st == TX_IDLE && sync && err_any && !rx_end |=> tx_st == TX_IDLE) else $error("sync start with error");
	a_err_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		fer_q && !stat_wr |=> fer_q) else $error("error flag lost");
	a_read_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		buf_rd && !rx_end |=> !rx_full_q) else $error("read left receive-full set");
	a_stop_mark: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_stop_sent |=> s_marked) else $error("no mark after last stop bit");
endmodule

// ==== su_pkg.sv ====
package su_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h1;
	localparam logic [3:0] ADDR_TXBUF = 4'h2;
	localparam logic [3:0] ADDR_STAT = 4'h3;
	localparam logic [3:0] ADDR_RXBUF = 4'h4;
	localparam logic [3:0] ADDR_PORT = 4'h5;
	localparam logic [3:0] ADDR_BAUD = 4'h6;
	// Mode register fields
	localparam int MODE_SYNC = 7;
	localparam int MODE_PAR_EN = 5;
	localparam int MODE_PAR_ODD = 4;
	// Control register fields
	localparam int CTRL_TXE_IE = 7;
	localparam int CTRL_RX_IE = 6;
	localparam int CTRL_TX_ON = 5;
	localparam int CTRL_RX_ON = 4;
	localparam int CTRL_TXD_IE = 2;
	localparam int CTRL_CKS1 = 1;
	localparam int CTRL_CKS0 = 0;
	// Status register fields
	localparam int STAT_TXE = 7;
	localparam int STAT_RXF = 6;
	localparam int STAT_OVR = 5;
	localparam int STAT_FER = 4;
	localparam int STAT_PER = 3;
	localparam int STAT_TXD = 2;
	// Port register fields
	localparam int PORT_DIR = 1;
	localparam int PORT_DAT = 0;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] BUF_RST = 8'h00;
	// Timing counts in basic-clock ticks and bits
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_PT = 4'h8;
	localparam logic [2:0] BITS_LAST = 3'h7;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} su_rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} su_tx_state_t;
endpackage

// ==== su_baud.sv ====
`timescale 1ns/1ps
module su_baud (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] divisor,
	output logic tick
);
	import su_pkg::*;
	logic [7:0] cnt_q;

	// Basic clock: one pulse every divisor+1 cycles
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= BAUD_RST;
		end else if (cnt_q >= divisor) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	assign tick = (cnt_q >= divisor);
endmodule

// ==== su_rx.sv ====
`timescale 1ns/1ps
module su_rx (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic rx_line,
	input wire logic tick,
	input wire logic enable,
	input wire logic par_en,
	input wire logic par_odd,
	output logic rx_lvl,
	output logic done,
	output logic [7:0] data,
	output logic par_err,
	output logic frm_err
);
	import su_pkg::*;
	su_rx_state_t st_q;
	logic s1_q, s2_q, s3_q, lvl_q;
	logic [3:0] ph_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic perr_q, done_q, ferr_q;
	logic smp;

	// Three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			lvl_q <= 1'b1;
		end else begin
			s1_q <= rx_line;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) lvl_q <= s3_q;
		end
	end

	// Mid-bit sample on the 8th basic-clock edge after the start edge
	assign smp = tick && (ph_q == SAMPLE_PT);

	// Frame engine; idle restarts on a low level so a break keeps framing
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= RX_IDLE;
			ph_q <= 4'h0;
			bit_q <= 3'h0;
			sh_q <= BUF_RST;
			perr_q <= 1'b0;
			done_q <= 1'b0;
			ferr_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!enable) begin
				st_q <= RX_IDLE;
			end else begin
				if (tick) ph_q <= ph_q + 4'h1;
				unique case (st_q)
					RX_IDLE: begin
						ph_q <= 4'h0;
						if (tick && !lvl_q) st_q <= RX_START;
					end
					RX_START: if (smp) begin
						st_q <= lvl_q ? RX_IDLE : RX_DATA;
						bit_q <= 3'h0;
					end
					RX_DATA: if (smp) begin
						sh_q <= {lvl_q, sh_q[7:1]};
						bit_q <= bit_q + 3'h1;
						if (bit_q == BITS_LAST) st_q <= par_en ? RX_PAR : RX_STOP;
					end
					RX_PAR: if (smp) begin
						perr_q <= (^sh_q) ^ lvl_q ^ par_odd;
						st_q <= RX_STOP;
					end
					RX_STOP: if (smp) begin
						ferr_q <= !lvl_q;
						if (!par_en) perr_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= RX_IDLE;
					end
				endcase
			end
		end
	end

	assign rx_lvl = lvl_q;
	assign done = done_q;
	assign data = sh_q;
	assign par_err = perr_q;
	assign frm_err = ferr_q;
endmodule

// ==== su_remote.sv ====
`timescale 1ns/1ps
module su_remote (
	input wire logic ref_clk,
	input wire logic tx_pin,
	output logic rx_line
);
	logic [7:0] got_q[$];
	logic [7:0] shift;
	// Idle line is mark
	initial rx_line = 1'b1;
	////////////////////////////////////////////////////////////////
	// One bit for a full bit time of sixteen basic ticks
	task automatic put(input logic b);
		rx_line <= b;
		repeat (16) @(posedge ref_clk);
	endtask
	// Whole frame, LSB first, optional parity, chosen stop level
	task automatic send(input logic [7:0] d, input logic has_par, input logic par, input logic stop);
		@(posedge ref_clk);
		put(1'b0);
		for (int i = 0; i < 8; i++) put(d[i]);
		if (has_par) put(par);
		put(stop);
		rx_line <= 1'b1;
	endtask
	// Break: line held at space
	task automatic hold_low(input int n);
		@(posedge ref_clk);
		rx_line <= 1'b0;
		repeat (n) @(posedge ref_clk);
		rx_line <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	// Mid-bit sampling of frames from the unit; junk frames are kept too
	initial begin
		forever begin
			@(negedge tx_pin);
			repeat (8) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (16) @(posedge ref_clk);
				shift[i] = tx_pin;
			end
			repeat (16) @(posedge ref_clk);
			got_q.push_back(shift);
		end
	end
endmodule

// ==== serial_irq_and_status_test.sv ====
`timescale 1ns/1ps
module serial_irq_and_status_test;
	import su_pkg::*;
	logic ref_clk, resetn, reg_wr, reg_rd, rx_line, tx_pin;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic tx_line_o, tx_line_oe_n, serial_clk_o, serial_clk_oe_n;
	logic rx_full_irq, tx_empty_irq, tx_done_irq, rx_error_irq, serial_irq;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	// Pull-up on the transmit wire while the unit leaves it floating
	assign tx_pin = tx_line_oe_n ? 1'b1 : tx_line_o;
	su_serial_unit dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line(rx_line), .tx_line_o(tx_line_o),
		.tx_line_oe_n(tx_line_oe_n), .serial_clk_o(serial_clk_o), .serial_clk_oe_n(serial_clk_oe_n),
		.rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
		.rx_error_irq(rx_error_irq), .serial_irq(serial_irq));
	su_remote remote (.ref_clk(ref_clk), .tx_pin(tx_pin), .rx_line(rx_line));
	////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Hang guard, well above the few thousand cycles needed
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("unexpected at %0t: run did not finish", $time);
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 800; i++) begin
			if (remote.got_q.size() >= n) break;
			@(posedge ref_clk);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		// Reset state, then transmit requests enabled before any data
		rd(ADDR_STAT, 8'h84);
		rd(4'hF, 8'h00);
		chk({7'h00, serial_irq}, 8'h00);
		wr(ADDR_CTRL, 8'h84);
		wait_clk(1);
		chk({6'h00, tx_empty_irq, tx_done_irq}, 8'h03);
		chk({7'h00, serial_irq}, 8'h01);
		// Two frames; the byte written over an unsent one is lost
		wr(ADDR_CTRL, 8'hA4);
		wr(ADDR_TXBUF, 8'hA5);
		wait_clk(40);
		wr(ADDR_TXBUF, 8'h11);
		wait_clk(1);
		chk({7'h00, tx_empty_irq}, 8'h00);
		wr(ADDR_TXBUF, 8'h22);
		wait_got(2);
		chk(remote.got_q[0], 8'hA5);
		chk(remote.got_q[1], 8'h22);
		wait_clk(20);
		rd(ADDR_STAT, 8'h84);
		chk({7'h00, tx_pin}, 8'h01);
		// Clean frame, then an overrun on the unread buffer
		wr(ADDR_CTRL, 8'h50);
		remote.send(8'h5A, 1'b0, 1'b0, 1'b1);
		wait_clk(4);
		chk({6'h00, rx_full_irq, rx_error_irq}, 8'h02);
		remote.send(8'hC3, 1'b0, 1'b0, 1'b1);
		wait_clk(4);
		rd(ADDR_STAT, 8'hE4);
		chk({7'h00, rx_error_irq}, 8'h01);
		wr(ADDR_CTRL, 8'h40);
		rd(ADDR_RXBUF, 8'h5A);
		rd(ADDR_STAT, 8'hA4);
		wr(ADDR_STAT, 8'h00);
		wait_clk(1);
		chk({6'h00, rx_full_irq, rx_error_irq}, 8'h00);
		// Break: framing fault comes back after the one clear made during it
		wr(ADDR_CTRL, 8'h50);
		fork
			remote.hold_low(500);
			begin
				wait_clk(200);
				rd(ADDR_STAT, 8'h94);
				rd(ADDR_RXBUF, 8'h00);
				wr(ADDR_STAT, 8'h00);
				wait_clk(200);
				rd(ADDR_STAT, 8'h94);
			end
		join
		wr(ADDR_STAT, 8'h00);
		// Clean odd-parity frame, then an even-parity fault that still copies the byte
		wr(ADDR_MODE, 8'h30);
		wait_clk(20);
		remote.send(8'h01, 1'b1, 1'b0, 1'b1);
		wait_clk(4);
		rd(ADDR_STAT, 8'hC4);
		rd(ADDR_RXBUF, 8'h01);
		wr(ADDR_MODE, 8'h20);
		remote.send(8'h01, 1'b1, 1'b0, 1'b1);
		wait_clk(4);
		rd(ADDR_STAT, 8'h8C);
		rd(ADDR_RXBUF, 8'h01);
		// Synchronous transmit held while the parity fault stands
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_MODE, 8'h80);
		wr(ADDR_CTRL, 8'hA0);
		wr(ADDR_TXBUF, 8'h96);
		wait_clk(40);
		chk({5'h00, serial_clk_o, tx_empty_irq, serial_clk_oe_n}, 8'h04);
		wr(ADDR_STAT, 8'h00);
		wait_clk(4);
		chk({6'h00, serial_clk_o, tx_empty_irq}, 8'h01);
		wait_clk(200);
		// Clock output released once CKS1 is set
		wr(ADDR_CTRL, 8'h02);
		wait_clk(1);
		chk({7'h00, serial_clk_oe_n}, 8'h01);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CTRL, 8'h00);
		// Transmit disabled mid-frame: pin follows the port latch
		wr(ADDR_PORT, 8'h02);
		// Byte written before the requests are enabled, so none fires at once
		wr(ADDR_TXBUF, 8'hFF);
		wr(ADDR_CTRL, 8'hA4);
		wait_clk(0);
		chk({6'h00, tx_empty_irq, tx_done_irq}, 8'h00);
		wait_clk(40);
		wr(ADDR_CTRL, 8'h00);
		wait_clk(2);
		chk({6'h00, tx_line_oe_n, tx_line_o}, 8'h00);
		wr(ADDR_PORT, 8'h03);
		wait_clk(1);
		chk({6'h00, tx_line_oe_n, tx_line_o}, 8'h01);
		rd(ADDR_PORT, 8'h03);
		close_out();
	end
endmodule
